// file: core/dprf_pkg.sv
// Constants and carrier types for the dual-port memory tile
// ==========================================================
// ==========================================================
package dprf_pkg;
    // Array geometry
    localparam int DPRF_ROWS    = 32'h0000_0200;
    localparam int DPRF_ROW_AW  = 32'h0000_0009;
    localparam int DPRF_ROW_W   = 32'h0000_0048;
    localparam int DPRF_DATA_W  = 32'h0000_0040;
    localparam int DPRF_CHK_W   = 32'h0000_0008;
    localparam int DPRF_SYN_W   = 32'h0000_0007;
    localparam int DPRF_ADDR_W  = 32'h0000_0010;
    localparam int DPRF_CAS_BIT = 32'h0000_000F; // Address bit choosing the tile
    localparam int DPRF_IDX_W   = 32'h0000_0006;
    localparam int DPRF_GRAN_DW = 32'h0000_0008; // Data bits of one 9-bit granule
    localparam int DPRF_LANE_W  = 32'h0000_0003; // Granule index bits within a row
    localparam int DPRF_PTR_W   = 32'h0000_000D;
    localparam logic [12:0] DPRF_CAP_FULL = 13'h1000; // Granules in full FIFO
    localparam logic [12:0] DPRF_CAP_HALF = 13'h0800; // Granules in half FIFO
    localparam logic [5:0]  DPRF_IDX_MASK = 6'h3F;

    // Port width codes: x1 x2 x4 x9 x18 x36 x72
    typedef logic [2:0] dprf_width_t;
    localparam dprf_width_t DPRF_W9  = 3'h3;
    localparam dprf_width_t DPRF_W18 = 3'h4;
    localparam dprf_width_t DPRF_W36 = 3'h5;
    localparam dprf_width_t DPRF_W72 = 3'h6;

    typedef enum logic [1:0] {DPRF_READ_FIRST, DPRF_WRITE_FIRST, DPRF_NO_CHANGE} dprf_wrmode_e;

    typedef struct packed {
        logic          fifoMode;
        logic          halfSplit;
        logic          splitReadWritePortMode;
        logic          eccEn;
        logic          outReg;
        logic          addrLatchOff;
        dprf_wrmode_e  wrModeA;
        dprf_wrmode_e  wrModeB;
        dprf_width_t   widthA;
        dprf_width_t   widthB;
        logic          casEn;
        logic          casPos;
        logic          casFifoIn;
        logic [12:0]   almostFullLevel;
        logic [12:0]   almostEmptyLevel;
    } dprf_cfg_s;

    typedef struct packed {
        logic          en;
        logic          we;
        logic [15:0]   addr;
        logic [71:0]   din;
    } dprf_req_s;

    typedef struct packed {
        logic [71:0]   dout;
        logic          singleErr;
        logic          doubleErr;
    } dprf_rsp_s;

    typedef struct packed {
        logic          full;
        logic          empty;
        logic          almostFull;
        logic          almostEmpty;
    } dprf_flags_s;

    typedef struct packed {
        logic          valid;
        logic [71:0]   data;
    } dprf_cas_s;

    typedef struct packed {
        logic [63:0]   encData;
        logic [71:0]   decWord;
    } dprf_ecc_in_s;

    typedef struct packed {
        logic [7:0]    encChk;
        dprf_rsp_s     dec;
    } dprf_ecc_out_s;

    typedef struct packed {
        logic [511:0][71:0] mem;
        dprf_rsp_s [1:0]    rsp;
        dprf_rsp_s [1:0]    pipe;
        logic [1:0]         hit;
        logic [1:0]         hitPipe;
        logic [1:0][15:0]   addr;
        logic [12:0]        wrPtr;
        logic [12:0]        rdPtr;
        dprf_flags_s        flags;
        dprf_ecc_out_s      eccOut;
    } dprf_state_s;
endpackage

// file: core/dprf_tile.sv
// Dual-port memory tile with FIFO controller, SECDED code and cascade
`timescale 1ns/1ps
`default_nettype none

module dprf_tile (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    input  wire dprf_pkg::dprf_cfg_s    cfg,
    input  wire logic                   powerDown,
    input  wire dprf_pkg::dprf_req_s    reqA,
    input  wire dprf_pkg::dprf_req_s    reqB,
    output var  dprf_pkg::dprf_rsp_s    rspA,
    output var  dprf_pkg::dprf_rsp_s    rspB,
    output var  dprf_pkg::dprf_flags_s  fifoFlags,
    input  wire dprf_pkg::dprf_cas_s    casIn,
    output var  logic                   casInReady,
    output var  dprf_pkg::dprf_cas_s    casOut,
    input  wire logic                   casOutReady,
    output var  dprf_pkg::dprf_req_s    casReqOut,
    input  wire dprf_pkg::dprf_ecc_in_s eccIn,
    output var  dprf_pkg::dprf_ecc_out_s eccOut
);

    // ==========================================================
    // Helper functions
    // ==========================================================

    // Mask of the low n bits of a row-wide word
    function automatic logic [71:0] lowMask(input int n);
        lowMask = ~({dprf_pkg::DPRF_ROW_W{1'b1}} << n);
    endfunction

    // Data and parity bits per lane for a width code
    function automatic int dataBits(input dprf_pkg::dprf_width_t w);
        if (w < dprf_pkg::DPRF_W9) begin
            dataBits = 1 << w;
        end else begin
            dataBits = dprf_pkg::DPRF_GRAN_DW << (w - dprf_pkg::DPRF_W9);
        end
    endfunction

    function automatic int parBits(input dprf_pkg::dprf_width_t w);
        parBits = (w < dprf_pkg::DPRF_W9) ? 0 : (1 << (w - dprf_pkg::DPRF_W9));
    endfunction

    // Extract one lane: parity bits sit above the data bits
    function automatic logic [71:0] laneGet(input logic [71:0] row,
                                            input dprf_pkg::dprf_width_t w,
                                            input logic [5:0] idx);
        logic [71:0] dat;
        logic [71:0] par;
        int          dw;
        int          pw;
        dw  = dataBits(w);
        pw  = parBits(w);

        // Shift the chosen lane down to bit zero
        dat = {8'h00, row[63:0]} >> (idx * dw);
        par = {64'h0000_0000_0000_0000, row[71:64]} >> (idx * pw);
        laneGet = (dat & lowMask(dw)) | ((par & lowMask(pw)) << dw);
    endfunction

    // Replace one lane of a row, other lanes untouched
    function automatic logic [71:0] lanePut(input logic [71:0] row,
                                            input dprf_pkg::dprf_width_t w,
                                            input logic [5:0] idx,
                                            input logic [71:0] din);
        logic [71:0] dat;
        logic [71:0] par;
        int          dw;
        int          pw;
        dw  = dataBits(w);
        pw  = parBits(w);
        dat = {8'h00, row[63:0]};
        par = {64'h0000_0000_0000_0000, row[71:64]};

        // Clear the lane, then merge; parity rides alongside
        dat = (dat & ~(lowMask(dw) << (idx * dw))) | ((din & lowMask(dw)) << (idx * dw));
        par = (par & ~(lowMask(pw) << (idx * pw)))
            | (((din >> dw) & lowMask(pw)) << (idx * pw));
        lanePut = {par[7:0], dat[63:0]};
    endfunction

    // Clamp a port width to what the array mode allows
    function automatic dprf_pkg::dprf_width_t effWidth(input dprf_pkg::dprf_cfg_s c,
                                                       input dprf_pkg::dprf_width_t w,
                                                       input logic isWr);
        dprf_pkg::dprf_width_t lim;

        // Widest dual-port shape; split mode doubles it
        lim = c.halfSplit ? dprf_pkg::DPRF_W18 : dprf_pkg::DPRF_W36;
        if (c.splitReadWritePortMode) begin
            lim = c.halfSplit ? dprf_pkg::DPRF_W36 : dprf_pkg::DPRF_W72;
        end
        // Split write side is pinned; FIFO granule is x9
        if (c.splitReadWritePortMode && isWr && !c.fifoMode) begin
            effWidth = lim;
        end else if (c.fifoMode && w < dprf_pkg::DPRF_W9) begin
            effWidth = dprf_pkg::DPRF_W9;
        end else begin
            effWidth = (w > lim) ? lim : w;
        end
    endfunction

    // Row of an address; a half array pins the row MSB to its half
    function automatic logic [8:0] rowOf(input logic [15:0] a,
                                         input dprf_pkg::dprf_width_t w,
                                         input logic half,
                                         input logic hiHalf);
        logic [15:0] sh;

        // Narrow shapes spend low bits on the lane
        sh    = a >> (dprf_pkg::DPRF_W72 - w);
        rowOf = half ? {hiHalf, sh[dprf_pkg::DPRF_ROW_AW-2:0]} : sh[dprf_pkg::DPRF_ROW_AW-1:0];
    endfunction

    // SECDED check bits: Hamming over positions, top bit is overall parity
    function automatic logic [7:0] eccEncode(input logic [63:0] d);
        logic [7:0] c;
        int         j;

        // Data fills every non-power-of-two position
        c = 8'h00;
        j = 0;
        for (int pos = 1; pos < dprf_pkg::DPRF_ROW_W; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                for (int b = 0; b < dprf_pkg::DPRF_SYN_W; b++) begin
                    if (pos[b]) begin
                        c[b] = c[b] ^ d[j];
                    end
                end
                j++;
            end
        end
        // Overall parity splits single from double
        c[dprf_pkg::DPRF_SYN_W] = ^{d, c[6:0]};
        eccEncode = c;
    endfunction

    // Decode: correct one bit, flag two
    function automatic dprf_pkg::dprf_rsp_s eccDecode(input logic [71:0] w);
        dprf_pkg::dprf_rsp_s r;
        logic [7:0]          c;
        logic [6:0]          syn;
        logic                ovr;
        int                  j;

        // Syndrome names the flipped position
        c           = eccEncode(w[63:0]);
        syn         = c[6:0] ^ w[70:64];
        ovr         = ^w;
        r.dout      = w;
        r.singleErr = 1'b0;
        r.doubleErr = 1'b0;
        j           = 0;
        if (syn != 7'h00 && ovr) begin
            r.singleErr = 1'b1;
            for (int pos = 1; pos < dprf_pkg::DPRF_ROW_W; pos++) begin
                if ((pos & (pos - 1)) != 0) begin
                    if (pos == int'(syn)) begin
                        r.dout[j] = ~r.dout[j];
                    end
                    j++;
                end
            end
        end else if (syn != 7'h00) begin
            r.doubleErr = 1'b1;
        end else if (ovr) begin
            r.singleErr = 1'b1;
        end
        // Check bits leave in step with the data
        r.dout[71:64] = eccEncode(r.dout[63:0]);
        eccDecode = r;
    endfunction

    // Read answer, decoded when the code is on at full width
    function automatic dprf_pkg::dprf_rsp_s readRsp(input logic [71:0] word,
                                                    input dprf_pkg::dprf_width_t w,
                                                    input logic ecc);
        dprf_pkg::dprf_rsp_s r;
        r.dout      = word;
        r.singleErr = 1'b0;
        r.doubleErr = 1'b0;

        // Narrower shapes pass raw; x9 to x36 carry parity, x1 to x4 none
        readRsp     = (ecc && w == dprf_pkg::DPRF_W72) ? eccDecode(word) : r;
    endfunction

    // FIFO row of a granule pointer; the half FIFO uses the low half
    function automatic logic [8:0] fifoRow(input logic [12:0] p, input logic half);
        fifoRow = half ? {1'b0, p[10:3]} : p[11:3];
    endfunction

    // ==========================================================
    // State
    // ==========================================================
    // Whole tile state, registered in one place
    dprf_pkg::dprf_state_s         s_q;
    dprf_pkg::dprf_state_s         s_d;
    dprf_pkg::dprf_req_s [1:0]     req;
    dprf_pkg::dprf_width_t [1:0]   eff;

    // Port requests as an indexable pair
    assign req = {reqB, reqA};

    // Effective shapes of both ports
    always_comb begin
        eff[0] = effWidth(cfg, cfg.widthA, 1'b1);
        eff[1] = effWidth(cfg, cfg.widthB, 1'b0);
    end

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic [8:0]          row;
        logic [5:0]          idx;
        logic [71:0]         old;
        logic [71:0]         wd;
        logic                act;
        logic                look;
        logic                push;
        logic                pop;
        logic [12:0]         gW;
        logic [12:0]         gR;
        logic [12:0]         cap;
        logic [12:0]         occ;
        dprf_pkg::dprf_wrmode_e mode;

        // Defaults: no access, all state holds
        row  = 9'h000;
        idx  = 6'h00;
        old  = '0;
        wd   = '0;
        act  = 1'b0;
        look = 1'b0;
        push = 1'b0;
        pop  = 1'b0;
        occ  = 13'h0000;
        mode = dprf_pkg::DPRF_NO_CHANGE;
        gW   = 13'(1 << (eff[0] - dprf_pkg::DPRF_W9));
        gR   = 13'(1 << (eff[1] - dprf_pkg::DPRF_W9));
        cap  = cfg.halfSplit ? dprf_pkg::DPRF_CAP_HALF : dprf_pkg::DPRF_CAP_FULL;
        s_d  = s_q;

        // Output stage copies last answer every cycle
        s_d.pipe    = s_q.rsp;
        s_d.hitPipe = s_q.hit;

        // Standalone encoder and decoder for outside memories
        s_d.eccOut.encChk = eccEncode(eccIn.encData);
        s_d.eccOut.dec    = eccDecode(eccIn.decWord);

        if (!cfg.fifoMode) begin
            // RAM mode: port A then port B, each on its own controls
            // B in the same cycle sees what A wrote
            for (int p = 0; p < 2; p++) begin
                // Off-slot cascade address leaves port A idle
                act  = req[p].en && !powerDown
                    && (p != 0 || !cfg.casEn
                        || req[p].addr[dprf_pkg::DPRF_CAS_BIT] == cfg.casPos);
                look = act || cfg.addrLatchOff;
                if (look) begin
                    s_d.addr[p] = req[p].addr;
                end
                row  = rowOf(s_d.addr[p], eff[p], cfg.halfSplit,
                             cfg.splitReadWritePortMode ? 1'b0 : 1'(p));
                idx  = s_d.addr[p][5:0] & (dprf_pkg::DPRF_IDX_MASK >> eff[p]);
                old  = laneGet(s_d.mem[row], eff[p], idx);
                mode = (p == 0) ? cfg.wrModeA : cfg.wrModeB;
                if (act && req[p].we && !(cfg.splitReadWritePortMode && p == 1)) begin
                    // Store the lane, then pick the view
                    wd = req[p].din;
                    if (cfg.eccEn && eff[p] == dprf_pkg::DPRF_W72) begin
                        wd[71:64] = eccEncode(wd[63:0]);
                    end
                    s_d.mem[row] = lanePut(s_d.mem[row], eff[p], idx, wd);
                    s_d.hit[p]   = 1'b1;
                    case (mode)
                        dprf_pkg::DPRF_READ_FIRST: begin
                            s_d.rsp[p] = readRsp(old, eff[p], 1'b0);
                        end
                        dprf_pkg::DPRF_WRITE_FIRST: begin
                            s_d.rsp[p] = readRsp(laneGet(s_d.mem[row], eff[p], idx),
                                                 eff[p], 1'b0);
                        end
                        default: begin
                        end
                    endcase
                end else if (look && !(cfg.splitReadWritePortMode && p == 0)) begin
                    // Latching off re-reads the address each cycle
                    s_d.rsp[p] = readRsp(old, eff[p], cfg.eccEn);
                    s_d.hit[p] = act;
                end
            end
        end else begin
            // Pointers count granules so mixed widths agree
            // FIFO push from user port A or from the tile below
            push = cfg.casFifoIn ? casIn.valid : reqA.en;
            wd   = cfg.casFifoIn ? casIn.data : reqA.din;
            if (push && !s_q.flags.full && !powerDown) begin
                if (cfg.eccEn && eff[0] == dprf_pkg::DPRF_W72) begin
                    wd[71:64] = eccEncode(wd[63:0]);
                end
                row = fifoRow(s_q.wrPtr, cfg.halfSplit);
                idx = 6'(s_q.wrPtr[2:0] >> (eff[0] - dprf_pkg::DPRF_W9));
                s_d.mem[row] = lanePut(s_q.mem[row], eff[0], idx, wd);
                s_d.wrPtr    = s_q.wrPtr + gW;
            end

            // FIFO pop by user port B or by the tile above
            pop = cfg.casEn ? casOutReady : reqB.en;
            if (pop && !s_q.flags.empty && !powerDown) begin
                row = fifoRow(s_q.rdPtr, cfg.halfSplit);
                idx = 6'(s_q.rdPtr[2:0] >> (eff[1] - dprf_pkg::DPRF_W9));
                s_d.rsp[1] = readRsp(laneGet(s_q.mem[row], eff[1], idx),
                                     eff[1], cfg.eccEn);
                s_d.hit[1] = 1'b1;
                s_d.rdPtr  = s_q.rdPtr + gR;
            end
        end

        // Flags from the updated occupancy in granules
        // Full looks one write ahead to stop overruns
        occ = s_d.wrPtr - s_d.rdPtr;
        s_d.flags.full        = (occ + gW) > cap;
        s_d.flags.empty       = occ < gR;
        s_d.flags.almostFull  = occ >= (cap - cfg.almostFullLevel);
        s_d.flags.almostEmpty = occ <= cfg.almostEmptyLevel;
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Memory clears too; the FIFO leaves reset empty
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s_q                   <= '0;
            s_q.flags.empty       <= 1'b1;
            s_q.flags.almostEmpty <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================

    // Port answers, optionally one stage later; lower tile answers port A misses
    always_comb begin
        rspA = cfg.outReg ? s_q.pipe[0] : s_q.rsp[0];
        rspB = cfg.outReg ? s_q.pipe[1] : s_q.rsp[1];
        if (cfg.casEn && !cfg.fifoMode
            && !(cfg.outReg ? s_q.hitPipe[0] : s_q.hit[0])) begin
            rspA.dout      = casIn.data;
            rspA.singleErr = 1'b0;
            rspA.doubleErr = 1'b0;
        end
    end

    // Flags, cascade handshake and standalone code results
    // Cascade output shows the head before any pop
    always_comb begin
        fifoFlags  = s_q.flags;
        casInReady = cfg.fifoMode && cfg.casFifoIn && !s_q.flags.full;
        casOut.valid = cfg.fifoMode && cfg.casEn && !s_q.flags.empty;
        casOut.data  = laneGet(s_q.mem[fifoRow(s_q.rdPtr, cfg.halfSplit)], eff[1],
                               6'(s_q.rdPtr[2:0] >> (eff[1] - dprf_pkg::DPRF_W9)));
        casReqOut  = reqA;
        eccOut     = s_q.eccOut;
    end

endmodule
`default_nettype wire

// file: sim/dprf_tile_asserts.sv
// Checker for the memory tile ports
`timescale 1ns/1ps
`default_nettype none
module dprf_tile_asserts (
    input wire logic                    clock,
    input wire logic                    rst_b,
    input wire dprf_pkg::dprf_cfg_s     cfg,
    input wire logic                    powerDown,
    input wire dprf_pkg::dprf_req_s     reqA,
    input wire dprf_pkg::dprf_req_s     reqB,
    input wire dprf_pkg::dprf_rsp_s     rspA,
    input wire dprf_pkg::dprf_rsp_s     rspB,
    input wire dprf_pkg::dprf_flags_s   fifoFlags,
    input wire logic                    casInReady,
    input wire dprf_pkg::dprf_req_s     casReqOut,
    input wire dprf_pkg::dprf_ecc_in_s  eccIn,
    input wire dprf_pkg::dprf_ecc_out_s eccOut
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Cascade links and FIFO refusals
    property p_casFwd; casReqOut == reqA; endproperty
    a_casFwd: assert property (p_casFwd) else $error("cascade forward");
    property p_casRdy; casInReady == (cfg.fifoMode && cfg.casFifoIn && !fifoFlags.full); endproperty
    a_casRdy: assert property (p_casRdy) else $error("cascade ready");
    property p_pushFull; cfg.fifoMode && !cfg.casEn && !cfg.casFifoIn && fifoFlags.full
        && reqA.en && !reqB.en |=> $stable(fifoFlags); endproperty
    a_pushFull: assert property (p_pushFull) else $error("push while full");
    property p_popEmpty; cfg.fifoMode && !cfg.casEn && !cfg.casFifoIn && fifoFlags.empty
        && reqB.en && !reqA.en && !cfg.outReg |=> fifoFlags.empty && $stable(rspB); endproperty
    a_popEmpty: assert property (p_popEmpty) else $error("pop while empty");
    // Port holding, gating and write policy
    property p_power; powerDown && !cfg.outReg && !cfg.addrLatchOff && !cfg.casEn
        |=> $stable(rspA) && $stable(rspB); endproperty
    a_power: assert property (p_power) else $error("gated port moved");
    property p_hold; !cfg.fifoMode && !cfg.outReg && !cfg.addrLatchOff && !reqB.en
        |=> $stable(rspB); endproperty
    a_hold: assert property (p_hold) else $error("idle port moved");
    property p_eccLat; $stable(eccIn) && $past(rst_b) |=> $stable(eccOut); endproperty
    a_eccLat: assert property (p_eccLat) else $error("code output moved");
    property p_wrFirst; reqA.en && reqA.we && !powerDown && !cfg.fifoMode && !cfg.outReg
        && !cfg.casEn && !cfg.halfSplit && !cfg.splitReadWritePortMode
        && cfg.wrModeA == dprf_pkg::DPRF_WRITE_FIRST && cfg.widthA == dprf_pkg::DPRF_W36
        |=> rspA.dout[35:0] == $past(reqA.din[35:0]); endproperty
    a_wrFirst: assert property (p_wrFirst) else $error("new data not shown");
    // Main scenarios reached
    c_full: cover property (fifoFlags.full && reqA.en);
    c_empty: cover property (fifoFlags.empty && reqB.en);
    c_single: cover property (eccOut.dec.singleErr);
endmodule
bind dprf_tile dprf_tile_asserts u_chk (.clock, .rst_b, .cfg, .powerDown, .reqA, .reqB,
    .rspA, .rspB, .fifoFlags, .casInReady, .casReqOut, .eccIn, .eccOut);
`default_nettype wire

// file: sim/dprf_user.sv
// User logic model driving both memory ports
`timescale 1ns/1ps
`default_nettype none
module dprf_user (
    input  wire logic                clock,
    output var  dprf_pkg::dprf_req_s reqA,
    output var  dprf_pkg::dprf_req_s reqB
);
    logic [35:0] seq;
    // Idle ports at time zero
    initial begin
        reqA = '0;
        reqB = '0;
        seq = '0;
    end
    // One access, request held for exactly one taking edge
    task automatic acc(input logic b, input logic we, input logic [15:0] ad,
                       input logic [71:0] d);
        @(posedge clock);
        if (b) reqB <= {1'b1, we, ad, d};
        else reqA <= {1'b1, we, ad, d};
        @(posedge clock);
        reqA.en <= 1'b0;
        reqB.en <= 1'b0;
        #1;
    endtask
    // Back-to-back pushes (A) or pops (B) carrying a running count
    task automatic burst(input logic b, input int n);
        repeat (n) begin
            @(posedge clock);
            if (b) reqB <= {1'b1, 1'b0, 16'h0000, 72'(seq)};
            else reqA <= {1'b1, 1'b1, 16'h0000, 72'(seq)};
            seq = seq + 36'h0_0000_0001;
        end
        @(posedge clock);
        reqA.en <= 1'b0;
        reqB.en <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// file: sim/dual_port_ram_fifo_ecc_bench.sv
// Self-checking bench for the memory tile
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, (e), (g)); end end
module dual_port_ram_fifo_ecc_bench;
    logic                    clock = 1'b0;
    logic                    rst_b = 1'b0;
    logic                    powerDown = 1'b0;
    dprf_pkg::dprf_cfg_s     cfg;
    dprf_pkg::dprf_ecc_in_s  eccIn = '0;
    dprf_pkg::dprf_req_s     reqA;
    dprf_pkg::dprf_req_s     reqB;
    dprf_pkg::dprf_rsp_s     rspA;
    dprf_pkg::dprf_rsp_s     rspB;
    dprf_pkg::dprf_flags_s   fifoFlags;
    dprf_pkg::dprf_ecc_out_s eccOut;
    dprf_pkg::dprf_cas_s     casIn = '0;
    dprf_pkg::dprf_cas_s     casOut;
    logic                    casInReady;
    logic                    casOutReady = 1'b0;
    int                      error_cnt = 0;
    int                      check_count = 0;
    logic [7:0]              chk;
    logic [35:0]             old;
    localparam logic [63:0]  D = 64'h0123_4567_89AB_CDEF;
    always #50 clock = ~clock;
    dprf_user u_usr (.clock, .reqA, .reqB);
    dprf_tile u_dut (.clock, .rst_b, .cfg, .powerDown, .reqA, .reqB, .rspA, .rspB, .fifoFlags,
        .casIn, .casInReady, .casOut, .casOutReady, .casReqOut(), .eccIn, .eccOut);
    // Counts, verdict and end of run
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst_b <= 1'b0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
    endtask
    // Hang guard
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop;
    end
    // Test sequence
    initial begin
        cfg = '0;
        cfg.widthA = dprf_pkg::DPRF_W36;
        cfg.widthB = dprf_pkg::DPRF_W36;
        cfg.almostEmptyLevel = 13'h0004;
        cfg.almostFullLevel = 13'h0008;
        do_reset;
        u_usr.acc(1'b0, 1'b1, 16'h0005, 72'h9_8765_4321);
        u_usr.acc(1'b0, 1'b1, 16'h0006, 72'h1_1111_2222);
        u_usr.acc(1'b1, 1'b0, 16'h0005, 72'h0);
        `CHK("B read", 36'h9_8765_4321, rspB.dout[35:0]);
        $display("Ports done");
        @(posedge clock);
        cfg.outReg <= 1'b1;
        u_usr.acc(1'b1, 1'b0, 16'h0006, 72'h0);
        `CHK("early", 36'h9_8765_4321, rspB.dout[35:0]);
        @(posedge clock);
        #1;
        `CHK("late", 36'h1_1111_2222, rspB.dout[35:0]);
        old = 36'h9_8765_4321;
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            cfg.outReg <= 1'b0;
            cfg.wrModeA <= dprf_pkg::dprf_wrmode_e'(k);
            u_usr.acc(1'b0, 1'b0, 16'h0006, 72'h0);
            u_usr.acc(1'b0, 1'b1, 16'h0005, 72'(36'hA_0000_0000 + 36'(k)));
            `CHK("wr view", (k == 0) ? old : (k == 1) ? 36'hA_0000_0001 : 36'h1_1111_2222,
                rspA.dout[35:0]);
            old = 36'hA_0000_0000 + 36'(k);
        end
        @(posedge clock);
        powerDown <= 1'b1;
        u_usr.acc(1'b0, 1'b1, 16'h0005, 72'h0);
        @(posedge clock);
        powerDown <= 1'b0;
        u_usr.acc(1'b1, 1'b0, 16'h0005, 72'h0);
        `CHK("gated", old, rspB.dout[35:0]);
        $display("Write policy done");
        @(posedge clock);
        eccIn.encData <= D;
        repeat (2) @(posedge clock);
        #1;
        chk = eccOut.encChk;
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            eccIn.decWord <= {chk, D ^ (((64'h1 << k) - 64'h1) << 5)};
            @(posedge clock);
            #1;
            if (k < 2) `CHK("dec data", D, eccOut.dec.dout[63:0]);
            `CHK("dec err", (k == 1) ? 2'h2 : (k == 2) ? 2'h1 : 2'h0,
                {eccOut.dec.singleErr, eccOut.dec.doubleErr});
        end
        @(posedge clock);
        cfg.splitReadWritePortMode <= 1'b1;
        {cfg.widthA, cfg.widthB} <= {dprf_pkg::DPRF_W72, dprf_pkg::DPRF_W72};
        u_usr.acc(1'b0, 1'b1, 16'h0000, {chk, D ^ 64'h20});
        @(posedge clock);
        cfg.eccEn <= 1'b1;
        u_usr.acc(1'b1, 1'b0, 16'h0000, 72'h0);
        `CHK("mem fix", {chk, D, 2'h2}, rspB);
        $display("Code done");
        @(posedge clock);
        cfg.fifoMode <= 1'b1;
        {cfg.eccEn, cfg.splitReadWritePortMode} <= 2'h0;
        {cfg.widthA, cfg.widthB} <= {dprf_pkg::DPRF_W36, dprf_pkg::DPRF_W36};
        do_reset;
        #1;
        `CHK("flags rst", 4'h5, fifoFlags);
        u_usr.burst(1'b0, 1);
        `CHK("flags one", 4'h1, fifoFlags);
        u_usr.burst(1'b0, 1024);
        `CHK("flags full", 4'hA, fifoFlags);
        for (int i = 0; i < 1024; i++) begin
            u_usr.acc(1'b1, 1'b0, 16'h0000, 72'h0);
            `CHK("pop", 36'(i), rspB.dout[35:0]);
        end
        `CHK("flags empty", 4'h5, fifoFlags);
        u_usr.acc(1'b1, 1'b0, 16'h0000, 72'h0);
        `CHK("pop refused", 36'h0_0000_03FF, rspB.dout[35:0]);
        @(posedge clock);
        {cfg.casEn, cfg.casFifoIn} <= 2'h3;
        casIn <= {1'b1, 72'h5_0505_0505};
        #1;
        `CHK("cas ready", 1'b1, casInReady);
        @(posedge clock);
        casIn.valid <= 1'b0;
        casOutReady <= 1'b1;
        #1;
        `CHK("cas head", {1'b1, 72'h5_0505_0505}, casOut);
        @(posedge clock);
        casOutReady <= 1'b0;
        #1;
        `CHK("cas pop", {1'b0, 36'h5_0505_0505}, {casOut.valid, rspB.dout[35:0]});
        $display("FIFO done");
        report_and_stop;
    end
endmodule
`default_nettype wire
